//--- core/sfpc_ctrl.sv
// self-program flash controller: control register, timed windows, buffer and sequencer
// Notes on behaviour
// - section busy bit always reads zero
// - ready irq while enabled, global on, pen clear
// - no ready irq during eeprom write or store
// - sig read plus pen: load within three returns byte
// - store after sig read command does nothing
// - reenable write clears whole temporary buffer
// - lock/fuse read within three cycles, z selects
// - page write stores buffer to upper z page
// - page write bit clears on finish or timeout
// - cpu halted for whole erase or write
// - page erase erases upper z page
// - page erase bit clears on finish or timeout
// - program enable opens four cycle store window
// - pen alone: store r1r0 into buffer word
// - pen clears after store or timeout
// - pen stays high during erase and write
// - only five legal command codes act
// - buffer erased after write, reenable, reset; load once
// - eeprom write blocks programming and fuse reads
// - eeprom write during loading discards buffer
// - programmed fuse/lock bits read zero
`timescale 1ns/1ps
module sfpc_ctrl
    import sfpc_pkg::*;
#(
    parameter int unsigned PROG_TICKS = SFPC_PROG_TICKS
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire sfpc_cpu_req_type   cpu_req,
    input  wire logic               irq_global_enable,
    input  wire logic               eeprom_write_busy,
    input  wire logic               ref_tick,
    input  wire sfpc_fuse_type      fuse_lock_prog,
    input  wire logic [31:0]        sig_row,
    output logic                    lpm_hit,
    output logic      [7:0]         lpm_data,
    output logic                    cpu_halt,
    output logic                    ready_irq,
    output sfpc_flash_cmd_type      flash_cmd
);
    typedef struct packed {
        logic [7:0]                  ctrl;
        logic [2:0]                  win;
        sfpc_fsm_type                fsm;
        logic [SFPC_TICK_W-1:0]      ticks;
        logic [SFPC_WIDX_W:0]        widx;
        logic [SFPC_PAGE_WORDS-1:0]  valid;
        logic                        ee_q;
        logic                        lpm_hit;
        logic [7:0]                  lpm_data;
        logic [31:0]                 prdata;
        sfpc_flash_cmd_type          flash;
    } sfpc_state_type;

    sfpc_state_type s_q;
    sfpc_state_type s_d;

    logic                   buf_we;
    logic [SFPC_WIDX_W-1:0] buf_waddr;
    logic [SFPC_WIDX_W-1:0] buf_raddr;
    logic [15:0]            buf_rdata;

    function automatic logic is_legal(input logic [4:0] cmd);
        is_legal = (cmd == SFPC_CMD_REENABLE) || (cmd == SFPC_CMD_LOCKFUSE) ||
                   (cmd == SFPC_CMD_PG_WRITE) || (cmd == SFPC_CMD_PG_ERASE) ||
                   (cmd == SFPC_CMD_LOAD);
    endfunction

    function automatic logic [SFPC_WIDX_W-1:0] z_word(input logic [15:0] z);
        z_word = z[SFPC_Z_WORD_LSB +: SFPC_WIDX_W];
    endfunction

    function automatic logic [7:0] fuse_pick(input sfpc_fuse_type f, input logic [1:0] sel);
        case (sel)
            2'h0:    fuse_pick = ~f.fuse_low;
            2'h1:    fuse_pick = ~f.lock_bits;
            2'h2:    fuse_pick = ~f.fuse_ext;
            default: fuse_pick = ~f.fuse_high;
        endcase
    endfunction

    logic reg_hit;
    logic apb_wr;
    logic apb_setup_rd;
    logic [4:0] cmd_q;
    logic pen_q;
    logic spm_ok;
    logic lpm_ok;
    logic busy_op;

    assign reg_hit      = (paddr == SFPC_REG_ADDR);
    assign apb_wr       = psel && penable && pwrite && reg_hit;
    assign apb_setup_rd = psel && !penable && !pwrite;
    assign cmd_q        = s_q.ctrl[SFPC_CMD_W-1:0];
    assign pen_q        = s_q.ctrl[SFPC_BIT_PROG_EN];
    assign busy_op      = (s_q.fsm != SFPC_ST_IDLE);
    // eeprom write blocks stores and fuse reads alike
    assign spm_ok = cpu_req.spm && pen_q && (s_q.win != 3'h0) && !busy_op &&
                    !eeprom_write_busy;
    assign lpm_ok = cpu_req.lpm && pen_q && (s_q.win >= SFPC_LPM_MIN_LEFT) &&
                    !busy_op && !eeprom_write_busy;

    always_comb begin
        s_d          = s_q;
        buf_we       = 1'b0;
        buf_waddr    = z_word(cpu_req.z);
        buf_raddr    = s_q.widx[SFPC_WIDX_W-1:0];
        s_d.ee_q     = eeprom_write_busy;
        s_d.lpm_hit  = 1'b0;
        s_d.flash.erase   = 1'b0;
        s_d.flash.prog_we = 1'b0;

        // window countdown; expiry drops the command unless an operation holds or starts it
        // a store on the last window cycle must keep erase/write bits for polling
        if (s_q.win != 3'h0) begin
            s_d.win = s_q.win - 3'h1;
            if (s_q.win == 3'h1 && !busy_op && !spm_ok) begin
                s_d.ctrl[SFPC_BIT_SIG_RD:0] = '0;
            end
        end

        // loaded data is lost if an eeprom write starts mid-fill
        if (eeprom_write_busy && !s_q.ee_q && (|s_q.valid)) begin
            s_d.valid = '0;
        end

        if (lpm_ok) begin
            if (cmd_q == SFPC_CMD_LOCKFUSE) begin
                s_d.lpm_hit  = 1'b1;
                s_d.lpm_data = fuse_pick(fuse_lock_prog, cpu_req.z[1:0]);
                s_d.ctrl[SFPC_BIT_SIG_RD:0] = '0;
                s_d.win = 3'h0;
            end else if (cmd_q == SFPC_CMD_LOAD && s_q.ctrl[SFPC_BIT_SIG_RD]) begin
                s_d.lpm_hit  = 1'b1;
                s_d.lpm_data = sig_row[{cpu_req.z[1:0], 3'h0} +: 8];
                s_d.ctrl[SFPC_BIT_SIG_RD:0] = '0;
                s_d.win = 3'h0;
            end
        end

        if (spm_ok) begin
            s_d.win = 3'h0;
            s_d.flash.page = cpu_req.z[SFPC_Z_PAGE_LSB +: SFPC_PAGE_W];
            case (cmd_q)
                SFPC_CMD_PG_ERASE: begin
                    s_d.fsm = SFPC_ST_ERASE;
                end
                SFPC_CMD_PG_WRITE: begin
                    s_d.fsm  = SFPC_ST_STREAM;
                    s_d.widx = '0;
                end
                SFPC_CMD_LOAD: begin
                    // a word already loaded since the last clear is not overwritten
                    if (!s_q.ctrl[SFPC_BIT_SIG_RD] && !s_q.valid[buf_waddr]) begin
                        buf_we = 1'b1;
                        s_d.valid[buf_waddr] = 1'b1;
                    end
                    s_d.ctrl[SFPC_BIT_SIG_RD:0] = '0;
                end
                default: begin
                    s_d.ctrl[SFPC_BIT_SIG_RD:0] = '0;
                end
            endcase
        end

        case (s_q.fsm)
            SFPC_ST_IDLE: begin
                s_d.ticks = '0;
            end
            SFPC_ST_ERASE: begin
                s_d.flash.erase = 1'b1;
                s_d.fsm = SFPC_ST_PROG;
            end
            SFPC_ST_STREAM: begin
                // read latency of one: word n is presented one cycle after its address
                if (s_q.widx != '0) begin
                    s_d.flash.prog_we = 1'b1;
                    s_d.flash.word = SFPC_WIDX_W'(s_q.widx - 6'h1);
                    s_d.flash.data = s_q.valid[s_d.flash.word] ? buf_rdata
                                                               : SFPC_ERASED_WORD;
                end
                if (s_q.widx == SFPC_STREAM_END) begin
                    s_d.fsm = SFPC_ST_PROG;
                end else begin
                    s_d.widx = s_q.widx + 6'h1;
                end
            end
            SFPC_ST_PROG: begin
                if (ref_tick) begin
                    s_d.ticks = s_q.ticks + 16'h1;
                end
                if (s_q.ticks >= SFPC_TICK_W'(PROG_TICKS)) begin
                    s_d.fsm = SFPC_ST_IDLE;
                    if (cmd_q == SFPC_CMD_PG_WRITE) begin
                        s_d.valid = '0;
                    end
                    s_d.ctrl[SFPC_BIT_SIG_RD:0] = '0;
                end
            end
            default: begin
                s_d.fsm = SFPC_ST_IDLE;
            end
        endcase

        if (apb_wr) begin
            s_d.ctrl[SFPC_BIT_IRQ_EN] = pwdata[SFPC_BIT_IRQ_EN];
            // commands only start while idle and no eeprom write runs
            if (is_legal(pwdata[SFPC_CMD_W-1:0]) && !busy_op && !pen_q &&
                !eeprom_write_busy) begin
                s_d.ctrl[SFPC_CMD_W-1:0] = pwdata[SFPC_CMD_W-1:0];
                s_d.ctrl[SFPC_BIT_SIG_RD] = pwdata[SFPC_BIT_SIG_RD] &&
                                           (pwdata[SFPC_CMD_W-1:0] == SFPC_CMD_LOAD);
                s_d.win = SFPC_SPM_WINDOW;
                if (pwdata[SFPC_CMD_W-1:0] == SFPC_CMD_REENABLE) begin
                    s_d.valid = '0;
                end
            end
        end
        s_d.ctrl[SFPC_BIT_BUSY] = 1'b0;

        if (apb_setup_rd) begin
            s_d.prdata = reg_hit ? {24'h0, s_q.ctrl} : SFPC_RDATA_NONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q        <= '0;
            s_q.ctrl   <= SFPC_REG_RESET;
            s_q.fsm    <= SFPC_ST_IDLE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    sfpc_page_buf u_buf (
        .clk   (clk),
        .ce    (ce),
        .we    (buf_we && ce),
        .waddr (buf_waddr),
        .wdata (cpu_req.r1r0),
        .raddr (buf_raddr),
        .rdata (buf_rdata)
    );

    // zero wait state slave; read data was captured in the setup cycle
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !reg_hit;
    assign prdata    = s_q.prdata;
    assign lpm_hit   = s_q.lpm_hit;
    assign lpm_data  = s_q.lpm_data;
    assign flash_cmd = s_q.flash;
    assign cpu_halt  = busy_op;
    assign ready_irq = s_q.ctrl[SFPC_BIT_IRQ_EN] && irq_global_enable && !pen_q &&
                       !eeprom_write_busy && !busy_op;
endmodule // sfpc_ctrl

//--- core/sfpc_page_buf.sv
// temporary page buffer memory with registered read data
`timescale 1ns/1ps
module sfpc_page_buf
    import sfpc_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   ce,
    input  wire logic                   we,
    input  wire logic [SFPC_WIDX_W-1:0] waddr,
    input  wire logic [15:0]            wdata,
    input  wire logic [SFPC_WIDX_W-1:0] raddr,
    output logic      [15:0]            rdata
);
    logic [15:0] mem [SFPC_PAGE_WORDS];

    // contents need no reset: per-word valid flags live in the controller
    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule // sfpc_page_buf

//--- pkg/sfpc_pkg.sv
// constants, carrier types and states for the self-program flash control block
package sfpc_pkg;
    // control/status register: printed offset 0x37 is not word aligned, kept as an index
    localparam logic [7:0]  SFPC_REG_INDEX  = 8'h37;
    localparam logic [11:0] SFPC_REG_ADDR   = {2'h0, SFPC_REG_INDEX, 2'h0};
    localparam logic [7:0]  SFPC_REG_RESET  = 8'h00;

    // field positions
    localparam int SFPC_BIT_IRQ_EN   = 7;
    localparam int SFPC_BIT_BUSY     = 6;
    localparam int SFPC_BIT_SIG_RD   = 5;
    localparam int SFPC_BIT_PROG_EN  = 0;
    localparam int SFPC_CMD_W        = 5;

    // legal low five bit commands
    localparam logic [4:0] SFPC_CMD_REENABLE = 5'h11;
    localparam logic [4:0] SFPC_CMD_LOCKFUSE = 5'h09;
    localparam logic [4:0] SFPC_CMD_PG_WRITE = 5'h05;
    localparam logic [4:0] SFPC_CMD_PG_ERASE = 5'h03;
    localparam logic [4:0] SFPC_CMD_LOAD     = 5'h01;

    // timed windows in clock cycles
    localparam logic [2:0] SFPC_SPM_WINDOW  = 3'h4;
    localparam logic [2:0] SFPC_LPM_WINDOW  = 3'h3;
    localparam logic [2:0] SFPC_LPM_MIN_LEFT = 3'(SFPC_SPM_WINDOW - SFPC_LPM_WINDOW + 3'h1);

    // page organisation (word index z[5:1], page z[15:6])
    localparam int SFPC_PAGE_WORDS = 32;
    localparam int SFPC_WIDX_W     = 5;
    localparam int SFPC_PAGE_W     = 10;
    localparam int SFPC_Z_WORD_LSB = 1;
    localparam int SFPC_Z_PAGE_LSB = 6;
    localparam logic [15:0] SFPC_ERASED_WORD = 16'hffff;
    localparam logic [SFPC_WIDX_W:0] SFPC_STREAM_END = 6'h20;

    // array programming time, timed by reference oscillator ticks
    localparam longint SFPC_PROG_TIME_NS  = 3700000;
    localparam longint SFPC_REF_PERIOD_NS = 125;
    localparam int SFPC_PROG_TICKS =
        int'((SFPC_PROG_TIME_NS + SFPC_REF_PERIOD_NS - 1) / SFPC_REF_PERIOD_NS);
    localparam int SFPC_TICK_W = 16;

    // apb answers
    localparam logic [31:0] SFPC_RDATA_NONE = 32'h0000_0000;

    typedef struct packed {
        logic        spm;
        logic        lpm;
        logic [15:0] z;
        logic [15:0] r1r0;
    } sfpc_cpu_req_type;

    // programmed fuse/lock bits are 1 here, read back inverted
    typedef struct packed {
        logic [7:0] fuse_high;
        logic [7:0] fuse_ext;
        logic [7:0] lock_bits;
        logic [7:0] fuse_low;
    } sfpc_fuse_type;

    typedef struct packed {
        logic                   erase;
        logic                   prog_we;
        logic [SFPC_PAGE_W-1:0] page;
        logic [SFPC_WIDX_W-1:0] word;
        logic [15:0]            data;
    } sfpc_flash_cmd_type;

    typedef enum logic [1:0] {
        SFPC_ST_IDLE,
        SFPC_ST_ERASE,
        SFPC_ST_STREAM,
        SFPC_ST_PROG
    } sfpc_fsm_type;
endpackage

//--- testbench/sfpc_cpu_model.sv
// cpu core model issuing program memory store and load instructions
`timescale 1ns/1ps
module sfpc_cpu_model
    import sfpc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        cpu_halt,
    output sfpc_cpu_req_type cpu_req,
    output logic             stall_timeout
);
    initial cpu_req = '0;
    initial stall_timeout = 1'b0;
    // operands scrambled after use so stale values never match by luck
    task automatic issue(input logic st, input logic [15:0] z, input logic [15:0] d);
        int k;
        k = 0;
        while (cpu_halt === 1'b1 && k < 500) begin
            @(posedge clk);
            k++;
        end
        if (cpu_halt === 1'b1) begin
            stall_timeout <= 1'b1;
        end
        cpu_req <= '{spm: st, lpm: !st, z: z, r1r0: d};
        @(posedge clk);
        cpu_req <= '{spm: 1'b0, lpm: 1'b0, z: ~z, r1r0: ~d};
    endtask
endmodule // sfpc_cpu_model

//--- testbench/sfpc_ctrl_bench.sv
// self-checking bench for the self-program flash controller
`timescale 1ns/1ps
module sfpc_ctrl_bench
    import sfpc_pkg::*;
;
    localparam int unsigned TICKS   = 4;
    localparam logic [31:0] FUSE    = 32'h1234_5678;
    localparam logic [31:0] FUSE_RD = ~FUSE;
    localparam logic [31:0] SIG     = 32'ha5c3_7e19; // arbitrary value
    logic               clk, rst, ce, psel, penable, pwrite, pready, pslverr, er;
    logic               irq_global_enable, eeprom_write_busy, ref_tick;
    logic               lpm_hit, cpu_halt, ready_irq, stall_timeout;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rv;
    logic [7:0]         lpm_data;
    logic [9:0]         er_page;
    logic [15:0]        seen [SFPC_PAGE_WORDS];
    int                 n_fail, n_tests;
    int                 n_er = 0, n_we = 0, tk = 0;
    sfpc_cpu_req_type   cpu_req;
    sfpc_flash_cmd_type flash_cmd;

    sfpc_ctrl #(.PROG_TICKS(TICKS)) dut (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cpu_req, .irq_global_enable, .eeprom_write_busy,
        .ref_tick, .fuse_lock_prog(FUSE), .sig_row(SIG), .lpm_hit, .lpm_data, .cpu_halt,
        .ready_irq, .flash_cmd);
    sfpc_cpu_model cpu (.clk, .cpu_halt, .cpu_req, .stall_timeout);

    always #4 clk = ~clk;
    // reference tick every fourth clock, with four ticks per operation, keeps the timed operations short
    always @(posedge clk) begin
        tk <= tk + 1;
        ref_tick <= (tk % 4) == 3;
        if (flash_cmd.erase) begin
            n_er <= n_er + 1;
            er_page <= flash_cmd.page;
        end
        if (flash_cmd.prog_we) begin
            n_we <= n_we + 1;
            seen[flash_cmd.word] <= flash_cmd.data;
        end
    end
    // a model stuck on halt ends the run at once
    always @(posedge clk) begin
        if (stall_timeout === 1'b1) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] e);
        apb(1'b0, SFPC_REG_ADDR, 8'h00);
        cmp(rv, {24'h0, e});
    endtask
    // halt is looked at on the falling edge, clear of the launching edge
    task automatic wait_idle();
        int k;
        @(negedge clk);
        for (k = 0; k < 400 && cpu_halt !== 1'b0; k++) @(negedge clk);
        if (cpu_halt !== 1'b0) begin
            n_fail++;
            end_of_test();
        end
        @(posedge clk);
    endtask
    task automatic load(input logic [15:0] z, input logic [15:0] d);
        apb(1'b1, SFPC_REG_ADDR, 8'h01);
        cpu.issue(1'b1, z, d);
    endtask
    task automatic page_write(input logic [15:0] a, input logic [15:0] b);
        int base;
        base = n_we;
        apb(1'b1, SFPC_REG_ADDR, 8'h05);
        cpu.issue(1'b1, 16'h0140, 16'hdead);
        wait_idle();
        cmp(n_we - base, 32);
        for (int i = 0; i < SFPC_PAGE_WORDS; i++)
            cmp(seen[i], i == 2 ? a : i == 31 ? b : SFPC_ERASED_WORD);
        rd(8'h00);
    endtask

    task automatic t_regs();
        logic [7:0] bad [4] = '{8'h07, 8'h13, 8'h02, 8'h1f};
        rd(SFPC_REG_RESET);
        apb(1'b1, SFPC_REG_ADDR, 8'hff);
        rd(8'h80);
        apb(1'b1, 12'h0d8, 8'h01);
        cmp(er, 1'b1);
        rd(8'h80);
        irq_global_enable <= 1'b1;
        @(negedge clk);
        cmp(ready_irq, 1'b1);
        @(posedge clk);
        eeprom_write_busy <= 1'b1;
        @(negedge clk);
        cmp(ready_irq, 1'b0);
        @(posedge clk);
        eeprom_write_busy <= 1'b0;
        apb(1'b1, SFPC_REG_ADDR, 8'h81);
        @(negedge clk);
        cmp(ready_irq, 1'b0);
        @(posedge clk);
        irq_global_enable <= 1'b0;
        rd(8'h81);
        rd(8'h80);
        foreach (bad[j]) begin
            apb(1'b1, SFPC_REG_ADDR, bad[j]);
            rd(8'h00);
        end
    endtask
    task automatic t_window();
        int base;
        base = n_er;
        apb(1'b1, SFPC_REG_ADDR, 8'h03);
        repeat (3) @(posedge clk);
        cpu.issue(1'b1, 16'ha940, 16'h0);
        @(negedge clk);
        cmp(cpu_halt, 1'b0);
        @(posedge clk);
        rd(8'h00);
        apb(1'b1, SFPC_REG_ADDR, 8'h03);
        repeat (2) @(posedge clk);
        cpu.issue(1'b1, 16'ha940, 16'h0);
        @(negedge clk);
        cmp(cpu_halt, 1'b1);
        @(posedge clk);
        rd(8'h03);
        wait_idle();
        cmp(n_er - base, 1);
        cmp(er_page, 10'h2a5);
        rd(8'h00);
    endtask
    task automatic t_discard(input logic ee);
        load(16'h0004, 16'h7777);
        if (ee) begin
            eeprom_write_busy <= 1'b1;
            @(posedge clk);
            eeprom_write_busy <= 1'b0;
            @(posedge clk);
        end else begin
            apb(1'b1, SFPC_REG_ADDR, 8'h11);
            cpu.issue(1'b1, 16'h0, 16'h0);
        end
        page_write(SFPC_ERASED_WORD, SFPC_ERASED_WORD);
    endtask
    // mid-run reset must drop loaded words and the register
    task automatic t_reset();
        load(16'h0010, 16'h4321);
        apb(1'b1, SFPC_REG_ADDR, 8'h80);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(SFPC_REG_RESET);
        page_write(SFPC_ERASED_WORD, SFPC_ERASED_WORD);
    endtask
    task automatic t_reads();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, SFPC_REG_ADDR, 8'h09);
            cpu.issue(1'b0, 16'(i), 16'h0);
            @(negedge clk);
            cmp(lpm_hit, 1'b1);
            cmp(lpm_data, FUSE_RD[8*i +: 8]);
            @(posedge clk);
            apb(1'b1, SFPC_REG_ADDR, 8'h21);
            cpu.issue(1'b0, 16'(i), 16'h0);
            @(negedge clk);
            cmp(lpm_data, SIG[8*i +: 8]);
            @(posedge clk);
        end
        apb(1'b1, SFPC_REG_ADDR, 8'h21);
        cpu.issue(1'b1, 16'h0, 16'h0);
        @(negedge clk);
        cmp(cpu_halt, 1'b0);
        @(posedge clk);
        page_write(SFPC_ERASED_WORD, SFPC_ERASED_WORD);
        eeprom_write_busy <= 1'b1;
        apb(1'b1, SFPC_REG_ADDR, 8'h09);
        cpu.issue(1'b0, 16'h0, 16'h0);
        @(negedge clk);
        cmp(lpm_hit, 1'b0);
        @(posedge clk);
        apb(1'b1, SFPC_REG_ADDR, 8'h03);
        rd(8'h00);
        eeprom_write_busy <= 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        {psel, penable, pwrite, irq_global_enable, eeprom_write_busy, ref_tick} = '0;
        paddr = '0;
        pwdata = '0;
        {n_fail, n_tests} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_window();
        load(16'h0005, 16'h1234);
        load(16'h0004, 16'hbeef);
        load(16'h003e, 16'h5a5a);
        page_write(16'h1234, 16'h5a5a);
        page_write(SFPC_ERASED_WORD, SFPC_ERASED_WORD);
        t_discard(1'b0);
        t_discard(1'b1);
        t_reset();
        t_reads();
        end_of_test();
    end
endmodule // sfpc_ctrl_bench

bind sfpc_ctrl sfpc_ctrl_sva #(.PROG_TICKS(PROG_TICKS)) u_sva (.clk, .rst, .psel, .penable,
    .pwrite, .prdata, .cpu_req, .irq_global_enable, .eeprom_write_busy, .ref_tick, .lpm_hit,
    .cpu_halt, .ready_irq, .flash_cmd);

//--- testbench/sfpc_ctrl_sva.sv
// concurrent checks on the ports of the self-program flash controller
`timescale 1ns/1ps
module sfpc_ctrl_sva
    import sfpc_pkg::*;
#(
    parameter int unsigned PROG_TICKS = SFPC_PROG_TICKS
) (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [31:0]        prdata,
    input wire sfpc_cpu_req_type   cpu_req,
    input wire logic               irq_global_enable,
    input wire logic               eeprom_write_busy,
    input wire logic               ref_tick,
    input wire logic               lpm_hit,
    input wire logic               cpu_halt,
    input wire logic               ready_irq,
    input wire sfpc_flash_cmd_type flash_cmd
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // stream position, so word order is checked too
    logic [5:0] run_q;
    logic [5:0] run_d;
    always_comb run_d = flash_cmd.prog_we ? run_q + 6'h01 : 6'h00;
    always_ff @(posedge clk) run_q <= rst ? 6'h00 : run_d;

    a_busy_zero: assert property (psel && penable && !pwrite |-> !prdata[SFPC_BIT_BUSY])
        else $error("busy bit read as one");
    a_irq_quiet: assert property (eeprom_write_busy || cpu_halt |-> !ready_irq)
        else $error("ready irq while busy");
    a_irq_gated: assert property (!irq_global_enable |-> !ready_irq)
        else $error("ready irq with interrupts off");
    a_halt_cause: assert property ($rose(cpu_halt) |->
        $past(cpu_req.spm) && !$past(eeprom_write_busy)) else $error("halt without store");
    a_erase_pulse: assert property (flash_cmd.erase |-> cpu_halt ##1 !flash_cmd.erase)
        else $error("erase pulse wrong");
    a_write_word: assert property (flash_cmd.prog_we |->
        cpu_halt && flash_cmd.word == run_q[4:0]) else $error("stream word out of order");
    a_stream_len: assert property ($fell(flash_cmd.prog_we) |-> run_q == 6'h20)
        else $error("stream length wrong");
    a_halt_ends: assert property ($fell(cpu_halt) |-> $past(ref_tick) || $past(ref_tick, 2))
        else $error("halt ended off a tick");
    a_lpm_pulse: assert property (lpm_hit |->
        $past(cpu_req.lpm) && !$past(eeprom_write_busy) ##1 !lpm_hit) else $error("bad load hit");

    c_erase: cover property (flash_cmd.erase);
    c_stream: cover property ($fell(flash_cmd.prog_we));
    c_lpm: cover property (lpm_hit);
endmodule // sfpc_ctrl_sva
